// File: verilog/orc_pkg.sv
// Function
// - With the RAM enable bit set, addresses H'FFDC00 to H'FFFBFF reach the on-chip RAM.
// - With the RAM enable bit clear, that range goes to the external space.
// - The RAM sits on a 16-bit data path and takes byte and word reads and writes.
// - Every RAM byte or word access, read or write, completes in one state.
// - Even-addressed bytes use the upper 8 lanes, odd-addressed bytes the lower 8.
// - The RAM enable bit is reloaded at reset release.
// - The RAM enable bit is bit 0 of system_control and comes out of reset as 1.
package orc_pkg;

   // ------------------------------------------------------------
   // address map of the work ram
   // ------------------------------------------------------------
   localparam int unsigned ORC_ADDR_W    = 24;
   localparam logic [23:0] ORC_RAM_BASE  = 24'hFFDC00;
   localparam logic [23:0] ORC_RAM_LAST  = 24'hFFFBFF;
   localparam int unsigned ORC_RAM_WORDS = 4096;
   localparam int unsigned ORC_DATA_W    = 16;
   localparam int unsigned ORC_LANE_W    = 8;
   localparam int unsigned ORC_LANES     = 2;

   // ------------------------------------------------------------
   // system_control register
   // ------------------------------------------------------------
   localparam int unsigned ORC_WB_ADR_W     = 4;
   localparam logic [3:0]  ORC_SYSCTL_OFS   = 4'h0;
   localparam logic [7:0]  ORC_SYSCTL_RST   = 8'h01;
   localparam logic [7:0]  ORC_SYSCTL_WMASK = 8'hBB;
   localparam int unsigned ORC_RAM_ENABLE_BIT_POS     = 0;

   // ------------------------------------------------------------
   // carriers and states
   // ------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic        we;
      logic        word;
      logic [23:0] addr;
      logic [15:0] wdata;
   } orc_req_t;

   typedef struct packed {
      logic        ack;
      logic [15:0] rdata;
   } orc_rsp_t;

   typedef enum {ORC_IDLE, ORC_EXT_WAIT} orc_state_t;

endpackage : orc_pkg

// File: verilog/orc_top.sv
`timescale 1ns/1ps
module orc_top
   import orc_pkg::*;
#(
   parameter int unsigned RAM_WORDS = ORC_RAM_WORDS
) (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_b,
   // wishbone register slave
   input  wire logic                    wb_cyc,
   input  wire logic                    wb_stb,
   input  wire logic                    wb_we,
   input  wire logic [ORC_WB_ADR_W-1:0] wb_adr,
   input  wire logic [3:0]              wb_sel,
   input  wire logic [31:0]             wb_dat_w,
   output      logic [31:0]             wb_dat_r,
   output      logic                    wb_ack,
   // processor bus
   input  wire orc_req_t                cpu_req,
   output      orc_rsp_t                cpu_rsp,
   // external address space
   output      orc_req_t                ext_req,
   input  wire orc_rsp_t                ext_rsp,
   // control bits
   output      logic [7:0]              sys_ctrl
);

   localparam int unsigned IDX_W = $clog2(RAM_WORDS);

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic logic orc_in_ram(input logic [23:0] a);
      return (a >= ORC_RAM_BASE) && (a <= ORC_RAM_LAST);
   endfunction : orc_in_ram

   // lane 1 is the upper byte, taken by even addresses
   function automatic logic [1:0] orc_lanes(input logic word,
                                            input logic odd);
      if (word) begin
         return 2'h3;
      end
      return odd ? 2'h1 : 2'h2;
   endfunction : orc_lanes

   logic [7:0]   sys_ctrl_ff;
   logic [31:0]  wb_dat_ff;
   logic         wb_ack_ff;
   orc_rsp_t     cpu_rsp_ff;
   orc_req_t     ext_req_ff;
   orc_state_t   state_ff;
   orc_state_t   nxt_state;
   logic         ram_en;
   logic         take;
   logic         in_ram;
   logic         ram_hit;
   logic         go_ext;
   logic         ext_done;
   logic [23:0]  ram_off;
   logic [IDX_W-1:0] ram_idx;
   logic [1:0]   lane_en;
   wire  [15:0]  ram_rd;
   logic         wb_req;
   logic         wb_hit;
   logic         wb_commit;

   // ------------------------------------------------------------
   // processor bus decode
   // ------------------------------------------------------------
   // request taken only while no external access is open
   assign ram_en   = sys_ctrl_ff[ORC_RAM_ENABLE_BIT_POS];
   assign take     = cpu_req.valid && (state_ff == ORC_IDLE);
   assign in_ram   = orc_in_ram(cpu_req.addr);
   assign ram_hit  = take && ram_en && in_ram;
   assign go_ext   = take && !(ram_en && in_ram);
   assign ext_done = (state_ff == ORC_EXT_WAIT) && ext_rsp.ack;

   // word index drops bit 0, so a word always covers both lanes
   assign ram_off = cpu_req.addr - ORC_RAM_BASE;
   assign ram_idx = ram_off[IDX_W:1];
   assign lane_en = orc_lanes(cpu_req.word, cpu_req.addr[0]);

   // ------------------------------------------------------------
   // ram array, one byte lane per generate block
   // ------------------------------------------------------------
   for (genvar l = 0; l < ORC_LANES; l++) begin : g_lane
      logic [ORC_LANE_W-1:0] lane_mem [RAM_WORDS];

      // byte write into this lane only when the lane is selected
      always_ff @(posedge clk) begin
         if (ram_hit && cpu_req.we && lane_en[l]) begin
            lane_mem[ram_idx] <= cpu_req.wdata[l*ORC_LANE_W +: ORC_LANE_W];
         end
      end

      assign ram_rd[l*ORC_LANE_W +: ORC_LANE_W] = lane_mem[ram_idx];
   end

   // ------------------------------------------------------------
   // access sequencing
   // ------------------------------------------------------------
   // external accesses wait for the far answer, ram ones never wait
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ORC_IDLE: begin
            if (go_ext) begin
               nxt_state = ORC_EXT_WAIT;
            end
         end
         ORC_EXT_WAIT: begin
            if (ext_rsp.ack) begin
               nxt_state = ORC_IDLE;
            end
         end
         default: begin
            nxt_state = ORC_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_ff <= ORC_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // answer to the processor, one state after a ram hit
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cpu_rsp_ff <= '0;
      end else begin
         cpu_rsp_ff.ack <= ram_hit || ext_done;
         if (ram_hit) begin
            cpu_rsp_ff.rdata <= ram_rd;
         end else if (ext_done) begin
            cpu_rsp_ff.rdata <= ext_rsp.rdata;
         end
      end
   end

   // request toward the external space, valid for one cycle
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ext_req_ff <= '0;
      end else if (go_ext) begin
         ext_req_ff <= cpu_req;
      end else begin
         ext_req_ff.valid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // wishbone slave for system_control
   // ------------------------------------------------------------
   assign wb_req    = wb_cyc && wb_stb;
   assign wb_hit    = (wb_adr == ORC_SYSCTL_OFS);
   assign wb_commit = wb_req && wb_ack_ff && wb_we && wb_hit && wb_sel[0];

   // ack one cycle after the strobe, dropped the cycle after
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wb_ack_ff <= 1'b0;
      end else begin
         wb_ack_ff <= wb_req && !wb_ack_ff;
      end
   end

   // read data, unmapped offsets read as zero
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wb_dat_ff <= '0;
      end else if (wb_req && !wb_ack_ff) begin
         wb_dat_ff <= wb_hit ? {24'h000000, sys_ctrl_ff} : 32'h00000000;
      end
   end

   // write lands on the acked edge, reserved bits stay zero
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sys_ctrl_ff <= ORC_SYSCTL_RST;
      end else if (wb_commit) begin
         sys_ctrl_ff <= (wb_dat_w[7:0] & ORC_SYSCTL_WMASK) |
                        (sys_ctrl_ff & ~ORC_SYSCTL_WMASK);
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign wb_dat_r = wb_dat_ff;
   assign wb_ack   = wb_ack_ff;
   assign cpu_rsp  = cpu_rsp_ff;
   assign ext_req  = ext_req_ff;
   assign sys_ctrl = sys_ctrl_ff;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // word write followed at once by a word read of the same word
   sequence s_word_wr_rd;
      (ram_hit && cpu_req.we && cpu_req.word) ##1
      (ram_hit && !cpu_req.we && cpu_req.word &&
       cpu_req.addr[23:1] == $past(cpu_req.addr[23:1]));
   endsequence

   // byte write then word read of the same word
   sequence s_byte_wr_rd(logic odd);
      (ram_hit && cpu_req.we && !cpu_req.word &&
       cpu_req.addr[0] == odd) ##1
      (ram_hit && !cpu_req.we && cpu_req.word &&
       cpu_req.addr[23:1] == $past(cpu_req.addr[23:1]));
   endsequence

   // write clearing the enable bit, then a request in the range
   sequence s_clear_then_req;
      (wb_commit && !wb_dat_w[ORC_RAM_ENABLE_BIT_POS]) ##1 (take && in_ram);
   endsequence

   a_ram_route: assert property (
      ram_hit |=> cpu_rsp_ff.ack && !ext_req_ff.valid)
      else $error("ram hit not answered by the ram");

   a_ext_route: assert property (
      (take && !ram_en && in_ram) |=> ext_req_ff.valid &&
      !cpu_rsp_ff.ack && ext_req_ff.addr == $past(cpu_req.addr))
      else $error("disabled ram range not sent outside");

   a_word_back: assert property (
      s_word_wr_rd |=> cpu_rsp_ff.rdata == $past(cpu_req.wdata, 2))
      else $error("word read does not return written word");

   a_one_state: assert property (
      (ram_hit ##1 !ram_hit) |=> !cpu_rsp_ff.ack &&
      $past(cpu_rsp_ff.ack))
      else $error("ram access not exactly one state");

   a_even_lane: assert property (
      s_byte_wr_rd(1'b0) |=>
      cpu_rsp_ff.rdata[15:8] == $past(cpu_req.wdata[15:8], 2))
      else $error("even byte not on upper lane");

   a_odd_lane: assert property (
      s_byte_wr_rd(1'b1) |=>
      cpu_rsp_ff.rdata[7:0] == $past(cpu_req.wdata[7:0], 2))
      else $error("odd byte not on lower lane");

   a_reset_load: assert property (
      $rose(rst_b) |-> ram_en && !ext_req_ff.valid)
      else $error("ram enable not reloaded at reset release");

   a_reset_value: assert property (
      $rose(rst_b) |-> sys_ctrl_ff == ORC_SYSCTL_RST)
      else $error("system_control reset value wrong");

   a_enable_next: assert property (
      s_clear_then_req |=> ext_req_ff.valid && !cpu_rsp_ff.ack)
      else $error("cleared enable not used by next access");

   // external access opened: request raised the cycle after taking
   sequence s_ext_open;
      go_ext ##1 ext_req_ff.valid;
   endsequence

   a_enable_land: assert property (
      wb_commit |=> ram_en == $past(wb_dat_w[ORC_RAM_ENABLE_BIT_POS]))
      else $error("ram enable write not landed on ack edge");

   a_ext_pulse: assert property (
      s_ext_open |=> !ext_req_ff.valid)
      else $error("external request longer than one cycle");

   a_ext_answer: assert property (
      ext_done |=> cpu_rsp_ff.ack &&
      cpu_rsp_ff.rdata == $past(ext_rsp.rdata))
      else $error("external answer not passed to processor");

   // register ack follows the taking edge and lasts one cycle
   a_wb_pulse: assert property (
      (wb_req && !wb_ack_ff) |=> wb_ack_ff ##1 !wb_ack_ff)
      else $error("register ack not a one-cycle pulse");

   // no answer without a request
   a_no_spurious: assert property (
      (state_ff == ORC_IDLE && !cpu_req.valid) |=> !cpu_rsp_ff.ack)
      else $error("processor answer without request");

endmodule : orc_top

// File: verification/orc_ext_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// external address space model
// ------------------------------------------------------------
module orc_ext_model
   import orc_pkg::*;
(
   // clock and reset
   input  wire logic     clk,
   input  wire logic     rst_b,
   // request from the block and answer delay
   input  wire orc_req_t ext_req,
   input  wire logic [3:0] delay,
   // answer
   output      orc_rsp_t ext_rsp
);
   logic       busy_ff;
   logic [3:0] cnt_ff;

   // answer delay+1 cycles after taking the request; data lines hold on the taking edge and toggle while idle or counting down
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         busy_ff <= 1'b0;
         cnt_ff  <= 4'h0;
         ext_rsp <= '0;
      end else if (ext_req.valid) begin
         busy_ff     <= 1'b1;
         cnt_ff      <= delay;
         ext_rsp.ack <= 1'b0;
      end else if (busy_ff && cnt_ff == 4'h0) begin
         busy_ff <= 1'b0;
         ext_rsp <= {1'b1, ext_req.addr[15:0] ^ 16'h5A5A};
      end else begin
         cnt_ff  <= cnt_ff - 4'h1;
         ext_rsp <= {1'b0, ~ext_rsp.rdata};
      end
   end
endmodule : orc_ext_model

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import orc_pkg::*;
();
   logic        clk, rst_b, wb_cyc, wb_stb, wb_we, wb_ack;
   logic [3:0]  wb_adr, wb_sel, dly;
   logic [31:0] wb_dat_w, wb_dat_r, rd;
   logic [7:0]  sys_ctrl;
   logic [15:0] q;
   orc_req_t    cpu_req, ext_req;
   orc_rsp_t    cpu_rsp, ext_rsp;
   int          n, error_cnt, checks;

   orc_top #(.RAM_WORDS(ORC_RAM_WORDS)) dut_u (.clk(clk), .rst_b(rst_b),
      .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
      .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
      .wb_ack(wb_ack), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp),
      .ext_req(ext_req), .ext_rsp(ext_rsp), .sys_ctrl(sys_ctrl));
   orc_ext_model ext_u (.clk(clk), .rst_b(rst_b), .ext_req(ext_req),
      .delay(dly), .ext_rsp(ext_rsp));

   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task stop_test;
      if (error_cnt == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test

   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // classic wishbone single cycle, held until ack
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} <= {2'b11, w, a, d};
      wb_sel <= 4'hF;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (wb_ack !== 1'b1 && i < 20);
      if (wb_ack !== 1'b1) begin
         error_cnt++;
         stop_test;
      end
      rd = wb_dat_r;
      {wb_cyc, wb_stb} <= 2'b00;
   endtask : wb

   // one processor access issued now; n counts cycles from taking edge
   task cpu_now(input logic w, input logic wd, input logic [23:0] a,
                input logic [15:0] d);
      cpu_req <= '{1'b1, w, wd, a, d};
      @(posedge clk);
      cpu_req.valid <= 1'b0;
      n = 1;
      #1;
      while (cpu_rsp.ack !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (cpu_rsp.ack !== 1'b1) begin
         error_cnt++;
         stop_test;
      end
      q = cpu_rsp.rdata;
   endtask : cpu_now

   // one processor access issued after the next edge
   task cpu(input logic w, input logic wd, input logic [23:0] a,
            input logic [15:0] d);
      @(posedge clk);
      cpu_now(w, wd, a, d);
   endtask : cpu

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_word;
      cpu(1'b1, 1'b1, ORC_RAM_BASE, 16'h1234);
      chk(n, 1);
      cpu(1'b1, 1'b1, 24'hFFFBFE, 16'hBEEF);
      cpu(0, 1'b1, ORC_RAM_BASE, 16'h0);
      chk({n[15:0], q}, {16'd1, 16'h1234});
      cpu(0, 1'b1, 24'hFFFBFE, 16'h0);
      chk(q, 16'hBEEF);
   endtask : t_word

   task t_lane;
      cpu(1'b1, 0, 24'hFFE000, 16'hAB00);
      cpu(1'b1, 0, 24'hFFE001, 16'h00CD);
      chk(n, 1);
      cpu(0, 0, 24'hFFE001, 16'h0);
      chk({n[23:0], q[7:0]}, {24'd1, 8'hCD});
      cpu(0, 1'b1, 24'hFFE000, 16'h0);
      chk(q, 16'hABCD);
   endtask : t_lane

   // back to back ram accesses, then an access right after disabling
   task t_b2b;
      @(posedge clk);
      cpu_req <= '{1'b1, 1'b1, 1'b1, 24'hFFE100, 16'h1111};
      @(posedge clk);
      cpu_req <= '{1'b1, 1'b0, 1'b1, 24'hFFE100, 16'h0000};
      @(posedge clk);
      cpu_req <= '{1'b1, 1'b1, 1'b0, 24'hFFE102, 16'h7700};
      #1;
      chk({cpu_rsp.ack, cpu_rsp.rdata}, {1'b1, 16'h1111});
      @(posedge clk);
      cpu_req <= '{1'b1, 1'b0, 1'b1, 24'hFFE102, 16'h0000};
      @(posedge clk);
      cpu_req <= '{1'b1, 1'b1, 1'b0, 24'hFFE103, 16'h0042};
      #1;
      chk({cpu_rsp.ack, cpu_rsp.rdata[15:8]}, {1'b1, 8'h77});
      @(posedge clk);
      cpu_req <= '{1'b1, 1'b0, 1'b1, 24'hFFE102, 16'h0000};
      @(posedge clk);
      cpu_req.valid <= 1'b0;
      #1;
      chk({cpu_rsp.ack, cpu_rsp.rdata}, {1'b1, 16'h7742});
      wb(1'b1, ORC_SYSCTL_OFS, 32'h0);
      cpu_now(0, 1'b1, 24'hFFE100, 16'h0);
      chk({n > 2, q}, {1'b1, 16'hE100 ^ 16'h5A5A});
      wb(1'b1, ORC_SYSCTL_OFS, 32'h1);
      #1;
      chk(sys_ctrl, 8'h01);
   endtask : t_b2b

   // just outside both ends of the ram window, prompt and slow far side
   task t_edge(input logic [3:0] d);
      dly <= d;
      cpu(0, 1'b1, 24'hFFDBFE, 16'h0);
      chk({n > 2, q}, {1'b1, 16'hDBFE ^ 16'h5A5A});
      cpu(0, 1'b1, 24'hFFFC00, 16'h0);
      chk({n > 2, q}, {1'b1, 16'hFC00 ^ 16'h5A5A});
   endtask : t_edge

   task t_off;
      wb(1'b1, ORC_SYSCTL_OFS, 32'h0);
      #1;
      chk(sys_ctrl, 8'h00);
      cpu(1'b1, 1'b1, ORC_RAM_BASE, 16'hDEAD);
      chk({ext_req.we, ext_req.word, ext_req.addr}, {2'b11, 24'hFFDC00});
      chk(ext_req.wdata, 16'hDEAD);
      cpu(0, 1'b1, ORC_RAM_BASE, 16'h0);
      chk({n > 2, q}, {1'b1, 16'hDC00 ^ 16'h5A5A});
      wb(1'b1, ORC_SYSCTL_OFS, 32'hFF);
      wb(0, ORC_SYSCTL_OFS, 32'h0);
      chk(rd, 32'hBB);
      cpu(0, 1'b1, ORC_RAM_BASE, 16'h0);
      chk({n[15:0], q}, {16'd1, 16'h1234});
   endtask : t_off

   task t_unmap;
      wb(1'b1, 4'h4, 32'h0);
      wb(0, 4'h4, 32'hFF);
      chk(rd, 32'h0);
      chk(sys_ctrl, 8'hBB);
   endtask : t_unmap

   task t_rst;
      wb(1'b1, ORC_SYSCTL_OFS, 32'h0);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      #1;
      chk(sys_ctrl, 8'h01);
      wb(0, ORC_SYSCTL_OFS, 32'h0);
      chk(rd, 32'h01);
   endtask : t_rst

   // main sequence
   initial begin
      {rst_b, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel} = '0;
      {wb_dat_w, cpu_req, dly, error_cnt, checks} = '0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      #1;
      chk(sys_ctrl, 8'h01);
      t_word;
      t_lane;
      t_b2b;
      t_edge(4'h0);
      t_edge(4'h5);
      t_off;
      t_unmap;
      t_rst;
      stop_test;
   end
endmodule : tb_top
